// ---- hw/sram_host_pkg.sv ----
// Constants, timing figures and carrier types for the dual-port static memory host
package sram_host_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int PORTS = 2;
	localparam int CNT_W = 4;

	// Clock and memory timing figures, in nanoseconds
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_WP_NS = 40;
	localparam int T_WZ_NS = 20;
	localparam int T_DW_NS = 20;
	localparam int T_AA_NS = 45;
	localparam int T_HZ_NS = 20;
	localparam int T_WDD_NS = 70;
	localparam int T_DDD_NS = 45;

	// Least time in whole cycles, never below one
	function automatic int cycles_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max_of(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int WR_PULSE_CYC = max_of(cycles_min(T_WP_NS), cycles_min(T_WZ_NS + T_DW_NS));
	localparam int RD_ACCESS_CYC = cycles_min(T_AA_NS);
	localparam int TURNOFF_CYC = cycles_min(T_HZ_NS);
	localparam int XPORT_CYC = max_of(cycles_min(T_WDD_NS), cycles_min(T_DDD_NS));

	localparam logic [CNT_W-1:0] WR_PULSE_CNT = CNT_W'(WR_PULSE_CYC);
	localparam logic [CNT_W-1:0] RD_ACCESS_CNT = CNT_W'(RD_ACCESS_CYC);
	localparam logic [CNT_W-1:0] TURNOFF_CNT = CNT_W'(TURNOFF_CYC);
	localparam logic [CNT_W-1:0] XPORT_CNT = CNT_W'(XPORT_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_WRITE,
		ST_READ,
		ST_RECOVER
	} port_state_t;

	// One access asked for by the user side
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sram_req_t;

	// Everything driven toward one memory port; control pins are active low
	typedef struct packed {
		logic selN;
		logic writeSelN;
		logic outEnN;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] portDataBusOut;
		logic portDataBusOe;
	} sram_drive_t;

endpackage

// ---- hw/sram_wait_timer.sv ----
// Down-counter that marks the last cycle of a loaded wait
`timescale 1ns/1ps
module sram_wait_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Control
	input wire logic load,
	input wire logic [sram_host_pkg::CNT_W-1:0] loadValue,
	// Status
	output logic done
);

	logic [sram_host_pkg::CNT_W-1:0] count_reg;
	logic [sram_host_pkg::CNT_W-1:0] count_next;

	assign count_next = load ? loadValue :
		(count_reg != sram_host_pkg::CNT_ZERO) ? count_reg - sram_host_pkg::CNT_ONE : count_reg;
	// Done ignores load: the host reloads on done, so gating it by load would loop
	assign done = (count_reg == sram_host_pkg::CNT_ONE);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count_reg <= sram_host_pkg::CNT_ZERO;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule // sram_wait_timer

// ---- hw/dual_port_sram_host.sv ----
// Host controller that drives both ports of an asynchronous dual-port static memory
`timescale 1ns/1ps

// Summary of operation
// R1: Write only while select and write-select low.
// R2: Address changes only with select high.
// R3: Select falls with write-select; outputs stay off.
// R4: OE low write: pulse covers turnoff plus setup.
// R5: OE high write: plain minimum pulse allowed.
// R6: Select high puts port in standby.
// R7: Memory drives data only while OE low.
// R8: Select and write-select low writes regardless OE.
// R9: Select low, write high, OE low reads.
// R10: Two independent ports reach whole array.
// R11: Same address on both ports not guaranteed.
// R12: Written data reaches other port after delay.
// R13: No host drive while memory outputs on.
// R14: Write commits when select or write-select rises.
module dual_port_sram_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// User requests, one lane per port
	input wire logic [sram_host_pkg::PORTS-1:0] reqValid,
	input wire sram_host_pkg::sram_req_t [sram_host_pkg::PORTS-1:0] reqInfo,
	output logic [sram_host_pkg::PORTS-1:0] reqReady,
	// Read answers
	output logic [sram_host_pkg::PORTS-1:0] rspValid,
	output logic [sram_host_pkg::PORTS-1:0][sram_host_pkg::DATA_W-1:0] rspData,
	// Memory port pins
	output sram_host_pkg::sram_drive_t [sram_host_pkg::PORTS-1:0] pinDrive,
	input wire logic [sram_host_pkg::PORTS-1:0][sram_host_pkg::DATA_W-1:0] portDataBusIn
);

	localparam int NP = sram_host_pkg::PORTS;

	function automatic logic addr_clash(
		input logic [sram_host_pkg::ADDR_W-1:0] a,
		input logic [sram_host_pkg::ADDR_W-1:0] b
	);
		return a == b;
	endfunction

	// Per-port state exported for the cross-port guard
	logic [NP-1:0] busy;
	logic [NP-1:0] recentWrite;
	logic [NP-1:0][sram_host_pkg::ADDR_W-1:0] curAddr;
	logic [NP-1:0][sram_host_pkg::ADDR_W-1:0] lastWriteAddr;
	logic [NP-1:0] idle;
	logic [NP-1:0] blocked;

	// The memory gives no arbitration, so two ports never touch one location at once, and a
	// read waits out the port-to-port delay after the other side wrote that location.
	// Port 0 wins a tie in the same cycle.
	assign blocked[0] = (busy[1] && addr_clash(curAddr[1], reqInfo[0].addr)) ||
		(recentWrite[1] && addr_clash(lastWriteAddr[1], reqInfo[0].addr)); // R11 R12
	assign blocked[1] = (busy[0] && addr_clash(curAddr[0], reqInfo[1].addr)) ||
		(recentWrite[0] && addr_clash(lastWriteAddr[0], reqInfo[1].addr)) ||
		(reqValid[0] && reqReady[0] && addr_clash(reqInfo[0].addr, reqInfo[1].addr)); // R11

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port // R10
			sram_host_pkg::port_state_t state_reg;
			sram_host_pkg::port_state_t state_next;
			sram_host_pkg::sram_req_t job_reg;
			logic selN_reg;
			logic writeSelN_reg;
			logic outEnN_reg;
			logic dataOe_reg;
			logic [sram_host_pkg::ADDR_W-1:0] addr_reg;
			logic [sram_host_pkg::DATA_W-1:0] rspData_reg;
			logic rspValid_reg;
			logic [sram_host_pkg::CNT_W-1:0] recent_reg;
			logic [sram_host_pkg::ADDR_W-1:0] wAddr_reg;
			logic timerLoad;
			logic [sram_host_pkg::CNT_W-1:0] timerValue;
			logic timerDone;
			logic accept;
			logic commit;

			assign accept = reqValid[p] && reqReady[p];
			assign commit = (state_reg == sram_host_pkg::ST_WRITE) && timerDone;

			assign timerLoad = (state_reg == sram_host_pkg::ST_SETUP) ||
				(state_reg == sram_host_pkg::ST_WRITE && timerDone) ||
				(state_reg == sram_host_pkg::ST_READ && timerDone);
			// R4: pulse is the larger of minimum width and turnoff plus data window
			assign timerValue = (state_reg == sram_host_pkg::ST_SETUP) ?
				(job_reg.write ? sram_host_pkg::WR_PULSE_CNT : sram_host_pkg::RD_ACCESS_CNT) :
				sram_host_pkg::TURNOFF_CNT; // R13

			sram_wait_timer u_timer (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.load(timerLoad),
				.loadValue(timerValue),
				.done(timerDone)
			);

			always_comb begin
				state_next = state_reg;
				unique case (state_reg)
					sram_host_pkg::ST_IDLE: begin
						if (accept) begin
							state_next = sram_host_pkg::ST_SETUP;
						end
					end
					sram_host_pkg::ST_SETUP: begin
						state_next = job_reg.write ? sram_host_pkg::ST_WRITE : sram_host_pkg::ST_READ;
					end
					sram_host_pkg::ST_WRITE, sram_host_pkg::ST_READ: begin
						if (timerDone) begin
							state_next = sram_host_pkg::ST_RECOVER;
						end
					end
					sram_host_pkg::ST_RECOVER: begin
						if (timerDone) begin
							state_next = sram_host_pkg::ST_IDLE;
						end
					end
				endcase
			end

			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					state_reg <= sram_host_pkg::ST_IDLE;
				end else begin
					state_reg <= state_next;
				end
			end

			// Latch the job; the address only moves while select is high
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					job_reg <= '0;
					addr_reg <= '0;
				end else if (accept) begin
					job_reg <= reqInfo[p];
					addr_reg <= reqInfo[p].addr; // R2
				end
			end

			// Control pins; idle level is deselected standby with outputs off
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					selN_reg <= 1'b1; // R6
					writeSelN_reg <= 1'b1;
					outEnN_reg <= 1'b1;
				end else if (state_reg == sram_host_pkg::ST_SETUP) begin
					// R3: select and write-select fall on the same edge, so outputs stay off
					selN_reg <= 1'b0; // R1 R8
					writeSelN_reg <= !job_reg.write;
					// R5: output enable stays high through a write
					outEnN_reg <= job_reg.write; // R7 R9
				end else if (timerDone && (state_reg == sram_host_pkg::ST_WRITE ||
						state_reg == sram_host_pkg::ST_READ)) begin
					// R14: both rise together, ending the write interval
					selN_reg <= 1'b1; // R6
					writeSelN_reg <= 1'b1;
					outEnN_reg <= 1'b1;
				end
			end

			// Data drive begins with the pulse, once memory outputs are known off, and
			// is held one cycle past the end of the write for hold time.
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					dataOe_reg <= 1'b0;
				end else if (state_reg == sram_host_pkg::ST_SETUP) begin
					dataOe_reg <= job_reg.write; // R13
				end else if (state_reg == sram_host_pkg::ST_RECOVER) begin
					dataOe_reg <= 1'b0;
				end
			end

			// Read capture after the access time
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					rspData_reg <= '0;
					rspValid_reg <= 1'b0;
				end else begin
					rspValid_reg <= (state_reg == sram_host_pkg::ST_READ) && timerDone;
					if ((state_reg == sram_host_pkg::ST_READ) && timerDone) begin
						rspData_reg <= portDataBusIn[p]; // R9
					end
				end
			end

			// Window after a write during which the opposite port may not read that location
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					recent_reg <= sram_host_pkg::CNT_ZERO;
					wAddr_reg <= '0;
				end else if (commit) begin
					recent_reg <= sram_host_pkg::XPORT_CNT; // R12
					wAddr_reg <= addr_reg;
				end else if (recent_reg != sram_host_pkg::CNT_ZERO) begin
					recent_reg <= recent_reg - sram_host_pkg::CNT_ONE;
				end
			end

			assign idle[p] = (state_reg == sram_host_pkg::ST_IDLE);
			assign busy[p] = !idle[p];
			assign curAddr[p] = addr_reg;
			assign recentWrite[p] = (recent_reg != sram_host_pkg::CNT_ZERO) || commit;
			assign lastWriteAddr[p] = commit ? addr_reg : wAddr_reg;
			assign reqReady[p] = idle[p] && !blocked[p];
			assign rspValid[p] = rspValid_reg;
			assign rspData[p] = rspData_reg;
			assign pinDrive[p].selN = selN_reg;
			assign pinDrive[p].writeSelN = writeSelN_reg;
			assign pinDrive[p].outEnN = outEnN_reg;
			assign pinDrive[p].addr = addr_reg;
			assign pinDrive[p].portDataBusOut = job_reg.data;
			assign pinDrive[p].portDataBusOe = dataOe_reg;
		end
	endgenerate

endmodule // dual_port_sram_host

// ---- test/dual_port_sram_host_checker.sv ----
// Pin timing and ordering checks for the dual-port memory host
`timescale 1ns/1ps
module dual_port_sram_host_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// User side
	input wire logic [1:0] reqValid,
	input wire sram_host_pkg::sram_req_t [1:0] reqInfo,
	input wire logic [1:0] reqReady,
	input wire logic [1:0] rspValid,
	input wire logic [1:0][7:0] rspData,
	// Memory pins
	input wire sram_host_pkg::sram_drive_t [1:0] pinDrive,
	input wire logic [1:0][7:0] portDataBusIn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire sram_host_pkg::sram_drive_t d0 = pinDrive[0];
	wire sram_host_pkg::sram_drive_t d1 = pinDrive[1];
	sequence wrEnd;
		$rose(d0.writeSelN) && $rose(d0.selN);
	endsequence
	sequence rdStart;
		$fell(d0.outEnN) && !d0.selN;
	endsequence
	addr_hold_a: assert property (!$stable(d0.addr) |-> d0.selN && $past(d0.selN))
		else $error("address moved while selected");
	wr_pulse_a: assert property ($fell(d0.writeSelN) |=> wrEnd)
		else $error("write pulse length wrong");
	wr_pulse1_a: assert property ($fell(d1.writeSelN) |=> $rose(d1.writeSelN))
		else $error("port one write pulse length wrong");
	wr_oe_a: assert property (!d0.writeSelN |-> d0.outEnN)
		else $error("output enable low in write");
	sel_fall_a: assert property ($fell(d0.writeSelN) |-> $fell(d0.selN) && d0.portDataBusOe)
		else $error("select and write-select apart");
	no_fight_a: assert property (d0.portDataBusOe |-> d0.outEnN && $past(d0.outEnN))
		else $error("host drove bus against memory");
	rd_answer_a: assert property (rdStart |-> ##2 rspValid[0])
		else $error("read answer late");
	rsp_pulse_a: assert property (rspValid[0] |=> !rspValid[0])
		else $error("read answer too long");
	ports_apart_a: assert property (!d0.writeSelN && !d1.selN |-> d0.addr != d1.addr)
		else $error("both ports on written address");
	no_fight1_a: assert property (d1.portDataBusOe |-> d1.outEnN && $past(d1.outEnN))
		else $error("port one host drove bus against memory");
	addr_hold1_a: assert property (!$stable(d1.addr) |-> d1.selN && $past(d1.selN))
		else $error("port one address moved while selected");
	rsp_pulse1_a: assert property (rspValid[1] |=> !rspValid[1])
		else $error("port one read answer too long");
endmodule // dual_port_sram_host_checker

bind dual_port_sram_host dual_port_sram_host_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reqValid(reqValid), .reqInfo(reqInfo), .reqReady(reqReady), .rspValid(rspValid),
	.rspData(rspData), .pinDrive(pinDrive), .portDataBusIn(portDataBusIn));

// ---- test/dual_port_sram_model.sv ----
// Behavioural two-port static memory facing the host
`timescale 1ns/1ps
module dual_port_sram_model (
	// Host pins
	input wire sram_host_pkg::sram_drive_t [1:0] pinDrive,
	// Resolved data bus of each port
	output logic [1:0][7:0] portDataBusIn
);
	logic [7:0] mem [0:4095];
	for (genvar p = 0; p < 2; p++) begin : g_port
		wire sram_host_pkg::sram_drive_t d = pinDrive[p];
		wire sram_host_pkg::sram_drive_t o = pinDrive[1-p];
		// Same location written by the other port gives no defined read data
		wire clash = !o.selN && !o.writeSelN && (o.addr == d.addr);
		wire writing = !d.selN && !d.writeSelN;
		wire reading = !d.selN && d.writeSelN && !d.outEnN;
		// Commit when the earlier of the two strobes rises
		always @(negedge writing) begin
			mem[d.addr] = d.portDataBusOut;
		end
		// An undriven bus shows the inverted byte so a badly timed sample fails
		// Written data shows on the other port at once, inside the port-to-port delay
		assign portDataBusIn[p] = d.portDataBusOe ? d.portDataBusOut :
			(reading && !clash) ? mem[d.addr] : ~mem[d.addr];
	end
endmodule // dual_port_sram_model

// ---- test/dual_port_sram_host_tb.sv ----
// Self-checking bench for the dual-port memory host
`timescale 1ns/1ps
module dual_port_sram_host_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] reqValid = 2'h0;
	sram_host_pkg::sram_req_t [1:0] reqInfo = '0;
	logic [1:0] reqReady;
	logic [1:0] rspValid;
	logic [1:0][7:0] rspData;
	logic [1:0][7:0] portDataBusIn;
	sram_host_pkg::sram_drive_t [1:0] pinDrive;
	int num_errors = 0;
	int compares = 0;
	always #20 clk_sys = ~clk_sys;
	dual_port_sram_host DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid),
		.reqInfo(reqInfo), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.pinDrive(pinDrive), .portDataBusIn(portDataBusIn));
	dual_port_sram_model mem (.pinDrive(pinDrive), .portDataBusIn(portDataBusIn));
	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h", $time, msg, got);
		end
	endtask
	task automatic hung;
		num_errors++;
		$display("unexpected at %0t: no handshake", $time);
		give_verdict();
	endtask
	task automatic request(input int p, input logic wr, input logic [11:0] a, input logic [7:0] dt);
		int n;
		@(negedge clk_sys);
		reqValid[p] = 1'b1;
		reqInfo[p] = '{write: wr, addr: a, data: dt};
		#1;
		for (n = 0; n < 20 && reqReady[p] !== 1'b1; n++) begin
			@(negedge clk_sys);
			#1;
		end
		if (n == 20) hung();
		@(negedge clk_sys);
		reqValid[p] = 1'b0;
	endtask
	task automatic read(input int p, input logic [11:0] a, input logic [7:0] exp);
		int n;
		request(p, 1'b0, a, 8'h00);
		for (n = 0; n < 10 && rspValid[p] !== 1'b1; n++) @(negedge clk_sys);
		if (n == 10) hung();
		check(rspData[p], exp, "read data");
	endtask
	task automatic t_idle;
		for (int p = 0; p < 2; p++) begin
			check({5'h0, pinDrive[p].selN, pinDrive[p].outEnN, pinDrive[p].portDataBusOe},
				8'h06, "idle pins");
		end
		check({6'h0, reqReady}, 8'h03, "ready after reset");
		$display("test idle done");
	endtask
	task automatic t_rw;
		for (int p = 0; p < 2; p++) begin
			request(p, 1'b1, 12'h000, 8'h5c + 8'(p));
			request(p, 1'b1, 12'hfff, 8'ha3 - 8'(p));
			read(p, 12'h000, 8'h5c + 8'(p));
			read(p, 12'hfff, 8'ha3 - 8'(p));
		end
		$display("test rw done");
	endtask
	task automatic t_cross;
		request(0, 1'b1, 12'h123, 8'ha5);
		read(1, 12'h123, 8'ha5);
		$display("test cross done");
	endtask
	task automatic t_both;
		fork
			request(0, 1'b1, 12'h010, 8'h3c);
			request(1, 1'b1, 12'h020, 8'hc3);
		join
		fork
			read(0, 12'h020, 8'hc3);
			read(1, 12'h010, 8'h3c);
		join
		$display("test both done");
	endtask
	task automatic t_clash;
		request(0, 1'b1, 12'h777, 8'h11);
		fork
			request(0, 1'b1, 12'h777, 8'h5a);
			read(1, 12'h777, 8'h5a);
		join
		$display("test clash done");
	endtask
	task automatic t_rerun;
		@(negedge clk_sys);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_idle();
		read(0, 12'h123, 8'ha5);
		$display("test rerun done");
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_idle();
		t_rw();
		t_cross();
		t_both();
		t_clash();
		t_rerun();
		give_verdict();
	end
endmodule // dual_port_sram_host_tb
